/* verilog/ddr2_cmd_core.sv */
// DDR2 device command decode, posted CAS, read framing, OCD and ODT logic
`timescale 1ns/10ps
`default_nettype none

module ddr2_cmd_core (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Memory link pins
    input wire logic i_mem_clk,
    input wire ddr2_cmd_pkg::pins_s i_pins,
    input wire logic [ddr2_cmd_pkg::DQ_W-1:0] i_dq,
    output logic [ddr2_cmd_pkg::DQ_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic o_dqs,
    output logic o_dqs_n,
    output logic o_dqs_oe,
    // Termination
    input wire logic i_self_refresh,
    output logic o_term_en,
    // Array side
    output ddr2_cmd_pkg::col_req_s o_col_req,
    output logic o_col_exec,
    output logic o_wr_start,
    output ddr2_cmd_pkg::rd_req_s o_rd_req,
    input wire logic [ddr2_cmd_pkg::DQ_W-1:0] i_rd_data,
    // Status
    output logic [ddr2_cmd_pkg::BANKS-1:0] o_bank_open,
    output logic [ddr2_cmd_pkg::STEP_W-1:0] o_pullup_step,
    output logic [ddr2_cmd_pkg::STEP_W-1:0] o_pulldown_step
);
    import ddr2_cmd_pkg::*;

    // ==========================================================
    // Functions
    function automatic cmd_e decode_cmd(input pins_s p);
        cmd_e c;
        c = CMD_NONE;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h0: c = CMD_MODE;
                3'h2: c = CMD_PRE;
                3'h3: c = CMD_ACT;
                3'h5: c = CMD_RD;
                3'h4: c = CMD_WR;
                default: c = CMD_NONE;
            endcase
        end
        return c;
    endfunction : decode_cmd

    // Returns {up_inc, up_dec, dn_inc, dn_dec}; code is {first, second, third, fourth}
    function automatic logic [3:0] decode_adjust(input logic [3:0] code);
        logic [3:0] act;
        act = 4'h0;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha: begin
                act = {code[0], code[1], code[2], code[3]};
            end
            default: act = 4'h0;
        endcase
        return act;
    endfunction : decode_adjust

    function automatic logic [STEP_W-1:0] step_next(input logic [STEP_W-1:0] s,
                                                    input logic inc, input logic dec);
        logic [STEP_W-1:0] r;
        r = s;
        if (inc && !dec && s != STEP_MAX) begin
            r = s + 4'h1;
        end else if (dec && !inc && s != STEP_MIN) begin
            r = s - 4'h1;
        end
        return r;
    endfunction : step_next

    function automatic logic [PEND_W-1:0] bit_at(input logic [3:0] idx);
        logic [PEND_W-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction : bit_at

    // ==========================================================
    // Synchronisers and link clock edges
    logic mclk_s1_ff, mclk_s2_ff, mclk_d_ff;
    pins_s pins_s1_ff, pins_s2_ff;
    // Idle pins: deselected, termination request low, so no false turn-on after reset
    localparam pins_s PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                    ba: '0, addr: '0, odt: 1'b0};
    logic [DQ_W-1:0] dq_s1_ff, dq_s2_ff;
    logic mrise, mfall;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mclk_s1_ff <= 1'b0;
            mclk_s2_ff <= 1'b0;
            mclk_d_ff <= 1'b0;
            pins_s1_ff <= PINS_IDLE;
            pins_s2_ff <= PINS_IDLE;
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            mclk_s1_ff <= i_mem_clk;
            mclk_s2_ff <= mclk_s1_ff;
            mclk_d_ff <= mclk_s2_ff;
            pins_s1_ff <= i_pins;
            pins_s2_ff <= pins_s1_ff;
            dq_s1_ff <= i_dq;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    assign mrise = mclk_s2_ff & ~mclk_d_ff;
    assign mfall = ~mclk_s2_ff & mclk_d_ff;

    cmd_e cmd;
    assign cmd = mrise ? decode_cmd(pins_s2_ff) : CMD_NONE;

    // ==========================================================
    // Mode registers
    logic [3:0] beats_ff, cl_ff, al_ff;
    logic [3:0] rl, wl;
    logic [2:0] ocd_field;

    assign rl = al_ff + cl_ff;
    assign wl = rl - 4'h1;
    assign ocd_field = pins_s2_ff.addr[OCD_LSB +: 3];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            beats_ff <= BL4_BEATS;
            cl_ff <= CL_RESET;
            al_ff <= AL_RESET;
        end else if (cmd == CMD_MODE && pins_s2_ff.ba == BA_MRS) begin
            beats_ff <= (pins_s2_ff.addr[BL_LSB +: 3] == BL_CODE_8) ? BL8_BEATS : BL4_BEATS;
            cl_ff <= {1'b0, pins_s2_ff.addr[CL_LSB +: 3]};
        end else if (cmd == CMD_MODE && pins_s2_ff.ba == BA_EMRS1) begin
            al_ff <= {1'b0, pins_s2_ff.addr[AL_LSB +: 3]};
        end
    end

    // ==========================================================
    // Bank state
    logic [BANKS-1:0] bank_open_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bank_open_ff <= '0;
        end else if (cmd == CMD_ACT) begin
            bank_open_ff[pins_s2_ff.ba] <= 1'b1;
        end else if (cmd == CMD_PRE) begin
            if (pins_s2_ff.addr[AP_BIT]) begin
                bank_open_ff <= '0;
            end else begin
                // Same index as activate: banks A, B, C, D are ba 00, 01, 10, 11
                bank_open_ff[pins_s2_ff.ba] <= 1'b0;
            end
        end
    end

    assign o_bank_open = bank_open_ff;

    // ==========================================================
    // Posted CAS and latency scheduling, counted in link clocks
    logic [PEND_W-1:0] exec_pend_ff, rd_pend_ff, wr_pend_ff, adj_pend_ff;
    col_req_s req_q_ff [PEND_W];
    logic is_acc, is_rd, is_wr, is_adj;
    logic exec_fire, rd_fire, pre_fire, wr_fire, adj_fire;

    assign is_rd = (cmd == CMD_RD);
    assign is_wr = (cmd == CMD_WR);
    assign is_acc = is_rd | is_wr;
    assign is_adj = (cmd == CMD_MODE) && (pins_s2_ff.ba == BA_EMRS1) && (ocd_field == OCD_ADJUST);

    // A bit placed at index n fires n link clocks later
    assign exec_fire = mrise && ((is_acc && al_ff == 4'h0) || exec_pend_ff[1]);
    assign rd_fire = mrise && rd_pend_ff[1];
    assign pre_fire = mrise && rd_pend_ff[2];
    assign wr_fire = mrise && wr_pend_ff[1];
    assign adj_fire = mrise && adj_pend_ff[1];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            exec_pend_ff <= '0;
            rd_pend_ff <= '0;
            wr_pend_ff <= '0;
            adj_pend_ff <= '0;
        end else if (mrise) begin
            exec_pend_ff <= (exec_pend_ff >> 1) | ((is_acc && al_ff != 4'h0) ? bit_at(al_ff) : '0);
            rd_pend_ff <= (rd_pend_ff >> 1) | (is_rd ? bit_at(rl) : '0);
            wr_pend_ff <= (wr_pend_ff >> 1) | (is_wr ? bit_at(wl) : '0);
            adj_pend_ff <= (adj_pend_ff >> 1) | (is_adj ? bit_at(wl) : '0);
        end
    end

    // Column requests held in a line indexed by remaining latency
    col_req_s new_req, exec_req;
    assign new_req = '{is_write: is_wr, bank: pins_s2_ff.ba, col: pins_s2_ff.addr};
    assign exec_req = (al_ff == 4'h0) ? new_req : req_q_ff[1];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < PEND_W; i++) begin
                req_q_ff[i] <= '0;
            end
        end else if (mrise) begin
            for (int i = 0; i < PEND_W - 1; i++) begin
                req_q_ff[i] <= req_q_ff[i+1];
            end
            req_q_ff[PEND_W-1] <= '0;
            if (is_acc && al_ff != 4'h0) begin
                req_q_ff[al_ff] <= new_req;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_col_req <= '0;
            o_col_exec <= 1'b0;
            o_wr_start <= 1'b0;
        end else begin
            o_col_exec <= exec_fire;
            o_wr_start <= wr_fire;
            if (exec_fire) begin
                o_col_req <= exec_req;
            end
        end
    end

    // ==========================================================
    // Read burst framing
    logic [3:0] beat_ff;
    logic burst_ff, preamble_ff;
    logic [1:0] rd_bank_ff;
    logic [ADDR_W-1:0] rd_col_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rd_bank_ff <= '0;
            rd_col_ff <= '0;
        end else if (exec_fire && !exec_req.is_write) begin
            rd_bank_ff <= exec_req.bank;
            rd_col_ff <= exec_req.col;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            beat_ff <= '0;
            burst_ff <= 1'b0;
            preamble_ff <= 1'b0;
        end else if (rd_fire) begin
            beat_ff <= 4'h1;
            burst_ff <= 1'b1;
            preamble_ff <= 1'b0;
        end else if (pre_fire && !burst_ff) begin
            preamble_ff <= 1'b1;
        end else if ((mrise || mfall) && burst_ff) begin
            if (beat_ff == beats_ff) begin
                burst_ff <= 1'b0;
            end else begin
                beat_ff <= beat_ff + 4'h1;
            end
        end
    end

    assign o_rd_req = '{bank: rd_bank_ff, col: rd_col_ff,
                        beat: rd_fire ? 3'h0 : beat_ff[2:0]};

    // ==========================================================
    // OCD drive mode and adjustable mode
    drive_e drive_ff, drive_req_ff;
    logic [3:0] oit_cnt_ff;
    logic [3:0] adj_bits_ff;
    logic [2:0] adj_phase_ff;
    logic [STEP_W-1:0] up_step_ff, dn_step_ff;
    logic [3:0] act;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            drive_ff <= DRV_OFF;
            drive_req_ff <= DRV_OFF;
            oit_cnt_ff <= '0;
        end else if (cmd == CMD_MODE && pins_s2_ff.ba == BA_EMRS1 &&
                     (ocd_field == OCD_DRIVE1 || ocd_field == OCD_DRIVE0 || ocd_field == OCD_EXIT)) begin
            case (ocd_field)
                OCD_DRIVE1: drive_req_ff <= DRV_HIGH;
                OCD_DRIVE0: drive_req_ff <= DRV_LOW;
                default: drive_req_ff <= DRV_OFF;
            endcase
            oit_cnt_ff <= OIT_CYCLES;
        end else if (oit_cnt_ff != 4'h0) begin
            oit_cnt_ff <= oit_cnt_ff - 4'h1;
            if (oit_cnt_ff == 4'h1) begin
                drive_ff <= drive_req_ff;
            end
        end
    end

    // Bits sampled on successive link clock edges, rising and falling, starting at write latency
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            adj_bits_ff <= '0;
            adj_phase_ff <= '0;
        end else if (adj_fire) begin
            adj_bits_ff <= {dq_s2_ff[0], 3'h0};
            adj_phase_ff <= 3'h1;
        end else if ((mrise || mfall) && adj_phase_ff != 3'h0) begin
            adj_bits_ff[3 - adj_phase_ff[1:0]] <= dq_s2_ff[0];
            adj_phase_ff <= (adj_phase_ff == 3'h3) ? 3'h4 : adj_phase_ff + 3'h1;
        end else if (adj_phase_ff == 3'h4) begin
            adj_phase_ff <= 3'h0;
        end
    end

    assign act = decode_adjust(adj_bits_ff);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            up_step_ff <= STEP_DEFAULT;
            dn_step_ff <= STEP_DEFAULT;
        end else if (cmd == CMD_MODE && pins_s2_ff.ba == BA_EMRS1 && ocd_field == OCD_DEFAULT) begin
            up_step_ff <= STEP_DEFAULT;
            dn_step_ff <= STEP_DEFAULT;
        end else if (adj_phase_ff == 3'h4) begin
            up_step_ff <= step_next(up_step_ff, act[3], act[2]);
            dn_step_ff <= step_next(dn_step_ff, act[1], act[0]);
        end
    end

    assign o_pullup_step = up_step_ff;
    assign o_pulldown_step = dn_step_ff;

    // ==========================================================
    // Output drivers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_n <= 1'b1;
            o_dqs_oe <= 1'b0;
        end else if (drive_ff != DRV_OFF) begin
            o_dq <= (drive_ff == DRV_HIGH) ? '1 : '0;
            o_dq_oe <= 1'b1;
            o_dqs <= (drive_ff == DRV_HIGH);
            o_dqs_n <= (drive_ff != DRV_HIGH);
            o_dqs_oe <= 1'b1;
        end else if (rd_fire || ((mrise || mfall) && burst_ff && beat_ff != beats_ff)) begin
            o_dq <= i_rd_data;
            o_dq_oe <= 1'b1;
            o_dqs <= mrise;
            o_dqs_n <= ~mrise;
            o_dqs_oe <= 1'b1;
        end else if (pre_fire && !burst_ff) begin
            o_dq_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_n <= 1'b1;
            o_dqs_oe <= 1'b1;
        end else if ((mrise || mfall) && (burst_ff || preamble_ff)) begin
            o_dq_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_n <= 1'b1;
            o_dqs_oe <= preamble_ff && !burst_ff;
        end else if (!burst_ff && !preamble_ff && !pre_fire) begin
            o_dq_oe <= 1'b0;
            o_dqs_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_n <= 1'b1;
        end
    end

    // ==========================================================
    // Termination
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_term_en <= 1'b0;
        end else begin
            o_term_en <= pins_s2_ff.odt && !i_self_refresh;
        end
    end

endmodule : ddr2_cmd_core

`default_nettype wire

/* shared/ddr2_cmd_pkg.sv */
// Constants and carrier types for the DDR2 command, OCD and ODT block
package ddr2_cmd_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned DQ_W = 16;
    localparam int unsigned BANKS = 4;
    localparam int unsigned PEND_W = 16;
    localparam int unsigned STEP_W = 4;

    // ==========================================================
    // Mode register fields
    localparam int unsigned BL_LSB = 0;
    localparam int unsigned CL_LSB = 4;
    localparam int unsigned AL_LSB = 3;
    localparam int unsigned OCD_LSB = 7;
    localparam int unsigned AP_BIT = 10;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [1:0] BA_MRS = 2'h0;
    localparam logic [1:0] BA_EMRS1 = 2'h1;
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DRIVE1 = 3'h1;
    localparam logic [2:0] OCD_DRIVE0 = 3'h2;
    localparam logic [2:0] OCD_ADJUST = 3'h4;
    localparam logic [2:0] OCD_DEFAULT = 3'h7;

    // ==========================================================
    // Reset values, burst lengths and step limits
    localparam logic [3:0] BL4_BEATS = 4'h4;
    localparam logic [3:0] BL8_BEATS = 4'h8;
    localparam logic [3:0] CL_RESET = 4'h3;
    localparam logic [3:0] AL_RESET = 4'h0;
    localparam logic [STEP_W-1:0] STEP_DEFAULT = 4'h8;
    localparam logic [STEP_W-1:0] STEP_MAX = 4'hf;
    localparam logic [STEP_W-1:0] STEP_MIN = 4'h0;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned T_OIT_PS = 12000;
    localparam int unsigned OIT_CYCLES_RAW = (T_OIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] OIT_CYCLES = (OIT_CYCLES_RAW < 1) ? 4'h1 : 4'(OIT_CYCLES_RAW);

    // ==========================================================
    // Types
    typedef enum logic [2:0] {CMD_NONE, CMD_MODE, CMD_PRE, CMD_ACT, CMD_RD, CMD_WR} cmd_e;
    typedef enum logic [1:0] {DRV_OFF, DRV_HIGH, DRV_LOW} drive_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic odt;
    } pins_s;

    typedef struct packed {
        logic is_write;
        logic [1:0] bank;
        logic [ADDR_W-1:0] col;
    } col_req_s;

    typedef struct packed {
        logic [1:0] bank;
        logic [ADDR_W-1:0] col;
        logic [2:0] beat;
    } rd_req_s;

endpackage : ddr2_cmd_pkg

/* dv/ddr2_cmd_core_sva.sv */
// Port checker for the DDR2 command core
`timescale 1ns/10ps
`default_nettype none
module ddr2_cmd_core_sva (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Watched ports
    input wire ddr2_cmd_pkg::pins_s i_pins,
    input wire logic i_self_refresh,
    input wire logic o_dq_oe,
    input wire logic o_dqs,
    input wire logic o_dqs_n,
    input wire logic o_dqs_oe,
    input wire logic o_term_en,
    input wire ddr2_cmd_pkg::col_req_s o_col_req,
    input wire logic o_col_exec,
    input wire logic o_wr_start,
    input wire logic [ddr2_cmd_pkg::BANKS-1:0] o_bank_open,
    input wire logic [ddr2_cmd_pkg::STEP_W-1:0] o_pullup_step,
    input wire logic [ddr2_cmd_pkg::STEP_W-1:0] o_pulldown_step
);
    import ddr2_cmd_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ==========================================================
    // Properties
    sequence s_preamble;
        (o_dqs_oe && !o_dqs && !o_dq_oe) [*8];
    endsequence
    property p_step(logic [3:0] s);
        $changed(s) |-> s == STEP_DEFAULT || (s == $past(s) + 4'h1 && s != 4'h0)
            || (s == $past(s) - 4'h1 && s != STEP_MAX);
    endproperty
    a_first_beat: assert property (s_preamble ##1 o_dq_oe |-> o_dqs)
        else $error("first beat not on a rising strobe");
    a_strobe_pair: assert property (o_dqs_oe |-> o_dqs_n == !o_dqs)
        else $error("strobe pair not complementary");
    a_data_strobe: assert property (o_dq_oe |-> o_dqs_oe)
        else $error("data driven without strobe");
    a_term_on: assert property ((i_pins.odt && !i_self_refresh) [*4] |-> o_term_en)
        else $error("termination not on");
    a_term_sref: assert property (i_self_refresh |=> !o_term_en)
        else $error("termination on in self refresh");
    a_pullup_step: assert property (p_step(o_pullup_step))
        else $error("pull-up step jumped or wrapped");
    a_pulldn_step: assert property (p_step(o_pulldown_step))
        else $error("pull-down step jumped or wrapped");
    a_col_hold: assert property ($changed(o_col_req) |-> o_col_exec)
        else $error("column request changed without exec");
    a_wr_latency: assert property (o_col_exec && o_col_req.is_write |-> ##[18:52] o_wr_start)
        else $error("write strobe start missing");
    a_desel_hold: assert property (i_pins.cs_n [*8] |-> $stable(o_bank_open))
        else $error("bank state changed while deselected");
endmodule : ddr2_cmd_core_sva

bind ddr2_cmd_core ddr2_cmd_core_sva chk_u (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_pins(i_pins), .i_self_refresh(i_self_refresh),
    .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_n(o_dqs_n), .o_dqs_oe(o_dqs_oe),
    .o_term_en(o_term_en), .o_col_req(o_col_req), .o_col_exec(o_col_exec),
    .o_wr_start(o_wr_start), .o_bank_open(o_bank_open), .o_pullup_step(o_pullup_step),
    .o_pulldown_step(o_pulldown_step)
);
`default_nettype wire

/* dv/mem_ctrl_model.sv */
// Memory controller model: link clock, command pins and adjust pattern
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model (
    // Link side
    output var logic o_mem_clk,
    output var ddr2_cmd_pkg::pins_s o_pins,
    output var logic [ddr2_cmd_pkg::DQ_W-1:0] o_dq
);
    import ddr2_cmd_pkg::*;
    realtime t_cmd;
    // ==========================================================
    // Free running link clock, unrelated in phase
    initial begin
        o_mem_clk = 1'b0;
        o_pins = {4'hf, 2'h0, 13'h0, 1'b0};
        o_dq = '0;
        t_cmd = 0.0;
        #3;
        forever #40 o_mem_clk = ~o_mem_clk;
    end
    // Command held across one rise, then deselect; spacing of two clocks
    task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
        @(negedge o_mem_clk);
        o_pins = {c, ba, a, o_pins.odt};
        @(posedge o_mem_clk);
        t_cmd = $realtime;
        @(negedge o_mem_clk);
        o_pins = {4'hf, ~ba, ~a, o_pins.odt};
    endtask : cmd
    task automatic set_odt(input logic v);
        o_pins.odt = v;
    endtask : set_odt
    // Adjust pattern at write latency two (AL 0, CL 3), then calibration exit
    task automatic adjust(input logic [3:0] code);
        cmd(4'h0, 2'h1, 13'h200);
        @(posedge o_mem_clk);
        for (int i = 3; i >= 0; i--) begin
            if (i[0]) @(negedge o_mem_clk);
            else @(posedge o_mem_clk);
            #30 o_dq = {16{code[i]}};
        end
        @(negedge o_mem_clk);
        #30 o_dq = ~o_dq;
        cmd(4'h0, 2'h1, 13'h0);
    endtask : adjust
endmodule : mem_ctrl_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking testbench for the DDR2 command core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ddr2_cmd_pkg::*;
    // ==========================================================
    // Clock, reset and wiring
    logic i_clk, i_rstn, i_self_refresh, mem_clk, dq_oe, dqs, dqs_n, dqs_oe, term_en;
    logic col_exec, wr_start, oe_ff;
    pins_s pins;
    col_req_s col_req;
    rd_req_s rd_req;
    logic [DQ_W-1:0] ctl_dq, dq_out, dq_wire, rd_data;
    logic [3:0] bank_open, pu, pd;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    realtime t_exec, t_wr, t_data;
    assign dq_wire = dq_oe ? dq_out : ctl_dq;
    assign rd_data = {rd_req.beat, rd_req.col};
    ddr2_cmd_core dut_u (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_mem_clk(mem_clk), .i_pins(pins), .i_dq(dq_wire),
        .o_dq(dq_out), .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_n(dqs_n), .o_dqs_oe(dqs_oe),
        .i_self_refresh(i_self_refresh), .o_term_en(term_en), .o_col_req(col_req),
        .o_col_exec(col_exec), .o_wr_start(wr_start), .o_rd_req(rd_req), .i_rd_data(rd_data),
        .o_bank_open(bank_open), .o_pullup_step(pu), .o_pulldown_step(pd)
    );
    mem_ctrl_model ctl (.o_mem_clk(mem_clk), .o_pins(pins), .o_dq(ctl_dq));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        oe_ff <= dq_oe;
        cycles <= cycles + 1;
        if (col_exec) t_exec = $realtime;
        if (wr_start) t_wr = $realtime;
        if (dq_oe && !oe_ff) t_data = $realtime;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic set_mode(input int al, input int cl, input logic bl8);
        ctl.cmd(4'h0, 2'h0, 13'((cl << 4) | (bl8 ? 3 : 2)));
        ctl.cmd(4'h0, 2'h1, 13'(al << 3));
    endtask : set_mode
    // ==========================================================
    // Scenarios
    task automatic t_banks;
        logic [3:0] exp;
        for (int b = 0; b < 4; b++) ctl.cmd(4'h3, 2'(b), 13'h0);
        ctl.cmd(4'h7, 2'h0, 13'h400);
        ctl.cmd(4'ha, 2'h0, 13'h400);
        tick(8);
        check(bank_open, 4'hf, "open after activates");
        exp = 4'hf;
        for (int b = 0; b < 4; b++) begin
            exp[b] = 1'b0;
            ctl.cmd(4'h2, 2'(b), 13'h0);
            tick(8);
            check(bank_open, exp, "single precharge");
        end
        ctl.cmd(4'h3, 2'h1, 13'h0);
        ctl.cmd(4'h3, 2'h2, 13'h0);
        ctl.cmd(4'h2, 2'h0, 13'h400);
        tick(8);
        check(bank_open, 4'h0, "precharge all");
    endtask : t_banks
    task automatic t_rw(input int al, input int cl, input logic bl8, input logic wr);
        int n;
        logic [12:0] col;
        col = 13'h5a3 ^ 13'(al);
        t_wr = 0.0;
        set_mode(al, cl, bl8);
        ctl.cmd(4'h3, 2'h2, 13'h0);
        ctl.cmd(wr ? 4'h4 : 4'h5, 2'h2, col);
        n = 0;
        while ((wr ? t_wr == 0.0 : dq_oe !== 1'b1) && n < 600) begin
            tick(1);
            n++;
        end
        check(col_req, {wr, 2'h2, col}, "column request");
        check(32'($rtoi((t_exec - ctl.t_cmd) / 80.0)), 32'(al), "posted delay");
        if (wr) begin
            check(32'($rtoi((t_wr - ctl.t_cmd) / 80.0)), 32'(al + cl - 1), "write lat");
        end else begin
            for (int b = 0; b < (bl8 ? 8 : 4); b++) begin
                check({dqs, dq_out}, {~b[0], 3'(b), col}, "read beat");
                tick(5);
            end
            check({dq_oe, dqs_oe}, 2'h0, "burst end");
            check(32'($rtoi((t_data - ctl.t_cmd) / 80.0)), 32'(al + cl), "read lat");
        end
        ctl.cmd(4'h2, 2'h0, 13'h400);
    endtask : t_rw
    task automatic t_drive;
        for (int m = 1; m < 4; m++) begin
            ctl.cmd(4'h0, 2'h1, 13'((m % 3) << 7));
            tick(6);
            if (m == 3) check({dq_oe, dqs_oe}, 2'h0, "drivers off");
            else check({dq_oe, dqs_oe, dqs, dqs_n, dq_out},
                {2'h3, m == 1, m == 2, {16{m == 1}}}, "drive level");
        end
    endtask : t_drive
    task automatic t_adjust;
        logic [3:0] up, dn;
        set_mode(0, 3, 1'b0);
        for (int c = 0; c < 16; c++) begin
            up = STEP_DEFAULT;
            dn = STEP_DEFAULT;
            case (c)
                1, 5, 9: up++;
                2, 6, 10: up--;
                default: ;
            endcase
            case (c)
                4, 5, 6: dn++;
                8, 9, 10: dn--;
                default: ;
            endcase
            ctl.cmd(4'h0, 2'h1, 13'h380);
            ctl.adjust(4'(c));
            check({pu, pd}, {up, dn}, "adjust code");
        end
        repeat (8) ctl.adjust(4'h5);
        check({pu, pd}, {STEP_MAX, STEP_MAX}, "top limit");
        repeat (16) ctl.adjust(4'ha);
        check({pu, pd}, {STEP_MIN, STEP_MIN}, "bottom limit");
    endtask : t_adjust
    task automatic t_odt;
        ctl.set_odt(1'b1);
        tick(5);
        check(term_en, 1'b1, "termination on");
        i_self_refresh = 1'b1;
        tick(2);
        check(term_en, 1'b0, "self refresh");
        i_self_refresh = 1'b0;
        ctl.set_odt(1'b0);
        tick(5);
        check(term_en, 1'b0, "termination off");
    endtask : t_odt
    // ==========================================================
    // Main sequence
    initial begin
        i_rstn = 1'b0;
        i_self_refresh = 1'b0;
        tick(6);
        i_rstn = 1'b1;
        tick(4);
        check({bank_open, pu, pd, dq_oe, dqs_oe, term_en, dqs_n}, 16'h0881, "reset");
        t_banks();
        t_rw(0, 3, 1'b0, 1'b0);
        t_rw(2, 4, 1'b1, 1'b0);
        t_rw(0, 3, 1'b0, 1'b1);
        t_rw(3, 5, 1'b0, 1'b1);
        t_drive();
        t_adjust();
        t_odt();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
